// File: hw/srwd_pkg.sv
// constants and types shared by the supply reset and watchdog supervisor
`default_nettype none

package srwd_pkg;
  // clock rate and time base
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  // nominal times, in microseconds
  localparam int unsigned POWER_UP_HOLD_TIME_US = 15_000;
  localparam int unsigned UNDERVOLT_FILTER_TIME_US = 15;
  localparam int unsigned WATCHDOG_PERIOD_US = 60_000;
  localparam int unsigned WATCHDOG_RESET_PULSE_US = 240;
  // the same times as clock cycles
  localparam int unsigned POWER_UP_HOLD_CYC = POWER_UP_HOLD_TIME_US * CYC_PER_US;
  localparam int unsigned UNDERVOLT_FILTER_CYC = UNDERVOLT_FILTER_TIME_US * CYC_PER_US;
  localparam int unsigned WATCHDOG_PERIOD_CYC = WATCHDOG_PERIOD_US * CYC_PER_US;
  localparam int unsigned WATCHDOG_RESET_PULSE_CYC = WATCHDOG_RESET_PULSE_US * CYC_PER_US;
  localparam int unsigned CNT_W = 24;
  // spi frame layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BITCNT_W = 5;
  localparam logic [BITCNT_W-1:0] BITCNT_VALID = 5'h10;
  localparam logic [BITCNT_W-1:0] BITCNT_SAT = 5'h1f;
  localparam int unsigned FRM_WR_BIT = 15;
  localparam int unsigned FRM_ADDR_MSB = 14;
  localparam int unsigned FRM_ADDR_LSB = 8;
  localparam int unsigned FRM_DATA_MSB = 7;
  localparam logic [6:0] ADDR_STATUS = 7'h00;
  localparam logic [6:0] ADDR_CMD = 7'h01;
  // status byte fields
  localparam int unsigned STAT_WDTO_BIT = 0;
  localparam int unsigned STAT_INHIBIT_BIT = 1;
  // output command register: bit0 ch2, bit1 ch4, bit2 ch5
  localparam logic [2:0] CMD_RST = 3'h0;
  // synchronised pin inputs
  localparam int unsigned NUM_PINS = 6;
  localparam int unsigned PIN_RISE_OK = 0;
  localparam int unsigned PIN_FALL_OK = 1;
  localparam int unsigned PIN_SEL_N = 2;
  localparam int unsigned PIN_INHIBIT = 3;
  localparam int unsigned PIN_CTRL_A = 4;
  localparam int unsigned PIN_CTRL_C = 5;
  localparam logic [NUM_PINS-1:0] PIN_RST = 6'h04;

  typedef enum logic [1:0] {
    SRWD_PWR_DOWN,
    SRWD_PWR_HOLD,
    SRWD_PWR_RUN
  } srwd_pwr_e;
endpackage : srwd_pkg

`default_nettype wire

// File: hw/srwd_supervisor.sv
// supply reset generator, undervoltage filter and spi watchdog supervisor
// Functional notes
// RULE1: hold reset for power-up time after rise
// RULE2: ignore supply dips shorter than filter time
// RULE3: long supply dip asserts reset output
// RULE4: rising threshold sits above falling threshold
// RULE5: during reset: stages off, spi ignored
// RULE6: high inhibit input disables the watchdog
// RULE7: host sends valid frame every watchdog period
// RULE8: only valid 16-bit frames restart watchdog
// RULE9: missed restart gives watchdog reset pulse
// RULE10: overflow switches all outputs off
// RULE11: overflow keeps register contents unchanged
// RULE12: overflow sets the timeout flag
// RULE13: first response after overflow is status
// RULE14: channels 1,3 resume on control input rise
// RULE15: channels 2,4,5 resume on command write
// RULE16: first status read clears timeout flag
// RULE17: power-up hold nominally fifteen milliseconds
// RULE18: times are elaboration-time counter parameters
`default_nettype none

module srwd_supervisor
  import srwd_pkg::*;
#(
  parameter int unsigned POR_HOLD_CYC_P = POWER_UP_HOLD_CYC,
  parameter int unsigned UV_FILTER_CYC_P = UNDERVOLT_FILTER_CYC,
  parameter int unsigned WD_PERIOD_CYC_P = WATCHDOG_PERIOD_CYC,
  parameter int unsigned WD_PULSE_CYC_P = WATCHDOG_RESET_PULSE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic rail_above_rise_thr_i,
  input wire logic rail_above_fall_thr_i,
  input wire logic watchdog_inhibit_i,
  input wire logic direct_drive_ctrl_a_i,
  input wire logic direct_drive_ctrl_c_i,
  input wire logic spi_sclk_i,
  input wire logic spi_select_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  output logic reset_out_n_o,
  output logic reset_out_n_oe_o,
  output logic [4:0] drive_en_o,
  output logic kline_tx_en_o
);
  localparam logic [CNT_W-1:0] POR_LAST = CNT_W'(POR_HOLD_CYC_P - 1); // RULE17 RULE18
  localparam logic [CNT_W-1:0] UV_LAST = CNT_W'(UV_FILTER_CYC_P - 1);
  localparam logic [CNT_W-1:0] WD_LAST = CNT_W'(WD_PERIOD_CYC_P - 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(WD_PULSE_CYC_P - 1);

  logic [NUM_PINS-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_prev_q;
  srwd_pwr_e pwr_q;
  logic [CNT_W-1:0] por_cnt_q, uv_cnt_q, wd_cnt_q, pulse_cnt_q;
  logic wd_pulse_q, reset_active, wd_en, wd_ovf, rst_drv_q;
  logic cs_rise, frame_valid, accept, restart, rd_status, wr_cmd;
  logic wdto_q, after_ovf_q, off_a_q, off_c_q, off_cmd_q, frame_tgl_q;
  logic [2:0] cmd_q;
  logic [7:0] status, rd_data_q;
  logic [15:0] resp_q;
  // link-side registers
  logic tgl_seen_q, new_frame;
  logic [BITCNT_W-1:0] bitcnt_q;
  logic [FRAME_BITS-1:0] shin_q, shout_q;

  // pin synchronisers; a change counts once stages two and three agree
  assign pin_raw = {direct_drive_ctrl_c_i, direct_drive_ctrl_a_i, watchdog_inhibit_i,
                    spi_select_n_i, rail_above_fall_thr_i, rail_above_rise_thr_i};
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        pin_s1_q[i] <= PIN_RST[i];
        pin_s2_q[i] <= PIN_RST[i];
        pin_s3_q[i] <= PIN_RST[i];
        pin_q[i] <= PIN_RST[i];
        pin_prev_q[i] <= PIN_RST[i];
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
        pin_prev_q[i] <= pin_q[i];
      end
    end
  end

  // supply supervision: hysteresis, dip filter and power-up hold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pwr_q <= SRWD_PWR_DOWN;
      por_cnt_q <= '0;
    end else begin
      unique case (pwr_q)
        SRWD_PWR_DOWN: begin
          por_cnt_q <= '0;
          if (pin_q[PIN_RISE_OK]) begin // RULE4
            pwr_q <= SRWD_PWR_HOLD;
          end
        end
        SRWD_PWR_HOLD: begin
          por_cnt_q <= por_cnt_q + 1'b1;
          if (uv_cnt_q == UV_LAST && !pin_q[PIN_FALL_OK]) begin
            pwr_q <= SRWD_PWR_DOWN;
          end else if (por_cnt_q == POR_LAST) begin // RULE1
            pwr_q <= SRWD_PWR_RUN;
          end
        end
        SRWD_PWR_RUN: begin
          if (uv_cnt_q == UV_LAST && !pin_q[PIN_FALL_OK]) begin // RULE3
            pwr_q <= SRWD_PWR_DOWN;
          end
        end
      endcase
    end
  end

  // dip length counter, only against the falling threshold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || pwr_q == SRWD_PWR_DOWN || pin_q[PIN_FALL_OK]) begin
      uv_cnt_q <= '0; // RULE2
    end else if (uv_cnt_q != UV_LAST) begin
      uv_cnt_q <= uv_cnt_q + 1'b1;
    end
  end

  assign reset_active = (pwr_q != SRWD_PWR_RUN) || wd_pulse_q;

  // frame end, validity and decoded commands
  assign cs_rise = pin_q[PIN_SEL_N] && !pin_prev_q[PIN_SEL_N];
  assign frame_valid = cs_rise && (bitcnt_q == BITCNT_VALID);
  assign accept = frame_valid && !reset_active; // RULE5
  assign rd_status = accept && !shin_q[FRM_WR_BIT]
                     && shin_q[FRM_ADDR_MSB:FRM_ADDR_LSB] == ADDR_STATUS;
  assign wr_cmd = accept && shin_q[FRM_WR_BIT]
                  && shin_q[FRM_ADDR_MSB:FRM_ADDR_LSB] == ADDR_CMD;
  assign restart = accept; // RULE8
  assign wd_en = (pwr_q == SRWD_PWR_RUN) && !pin_q[PIN_INHIBIT] && !wd_pulse_q; // RULE6
  assign wd_ovf = wd_en && !restart && (wd_cnt_q == WD_LAST);

  // watchdog period counter, first period starts at end of hold
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !wd_en || restart || wd_ovf) begin
      wd_cnt_q <= '0; // RULE7
    end else begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // watchdog reset pulse
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wd_pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (wd_ovf) begin
      wd_pulse_q <= 1'b1; // RULE9
      pulse_cnt_q <= '0;
    end else if (wd_pulse_q) begin
      pulse_cnt_q <= pulse_cnt_q + 1'b1;
      if (pulse_cnt_q == PULSE_LAST) begin
        wd_pulse_q <= 1'b0;
      end
    end
  end

  // timeout flag; a new overflow wins over the clearing read
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wdto_q <= 1'b0;
      after_ovf_q <= 1'b0;
    end else begin
      if (wd_ovf) begin
        wdto_q <= 1'b1; // RULE12
      end else if (rd_status) begin
        wdto_q <= 1'b0; // RULE16
      end
      if (wd_ovf) begin
        after_ovf_q <= 1'b1;
      end else if (accept) begin
        after_ovf_q <= 1'b0;
      end
    end
  end

  // channel lock-out after overflow
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      off_a_q <= 1'b0;
      off_c_q <= 1'b0;
      off_cmd_q <= 1'b0;
    end else begin
      if (wd_ovf) begin
        off_a_q <= 1'b1; // RULE10
        off_c_q <= 1'b1;
        off_cmd_q <= 1'b1;
      end else begin
        if (pin_q[PIN_CTRL_A] && !pin_prev_q[PIN_CTRL_A]) begin
          off_a_q <= 1'b0; // RULE14
        end
        if (pin_q[PIN_CTRL_C] && !pin_prev_q[PIN_CTRL_C]) begin
          off_c_q <= 1'b0; // RULE14
        end
        if (wr_cmd) begin
          off_cmd_q <= 1'b0; // RULE15
        end
      end
    end
  end

  // spi registers; overflow does not touch them
  assign status = {6'h00, pin_q[PIN_INHIBIT], wdto_q};
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cmd_q <= CMD_RST;
      rd_data_q <= 8'h00;
    end else if (accept) begin
      if (wr_cmd) begin
        cmd_q <= shin_q[2:0]; // RULE11
      end
      if (shin_q[FRM_ADDR_MSB:FRM_ADDR_LSB] == ADDR_STATUS) begin
        rd_data_q <= status;
      end else if (shin_q[FRM_ADDR_MSB:FRM_ADDR_LSB] == ADDR_CMD) begin
        rd_data_q <= {5'h00, cmd_q};
      end else begin
        rd_data_q <= 8'h00;
      end
    end
  end

  // response for the next frame and the frame toggle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      resp_q <= 16'h0000;
      frame_tgl_q <= 1'b0;
    end else begin
      resp_q <= after_ovf_q ? {8'h00, status} : {8'h00, rd_data_q}; // RULE13
      if (cs_rise) begin
        frame_tgl_q <= ~frame_tgl_q;
      end
    end
  end

  // reset output and output stage enables
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rst_drv_q <= 1'b1;
      drive_en_o <= 5'h00;
      kline_tx_en_o <= 1'b0;
    end else begin
      rst_drv_q <= reset_active;
      kline_tx_en_o <= !reset_active; // RULE5
      drive_en_o[0] <= !reset_active && !off_a_q && pin_q[PIN_CTRL_A];
      drive_en_o[1] <= !reset_active && !off_cmd_q && cmd_q[0];
      drive_en_o[2] <= !reset_active && !off_c_q && pin_q[PIN_CTRL_C];
      drive_en_o[3] <= !reset_active && !off_cmd_q && cmd_q[1];
      drive_en_o[4] <= !reset_active && !off_cmd_q && cmd_q[2];
    end
  end
  assign reset_out_n_o = 1'b0;
  assign reset_out_n_oe_o = rst_drv_q;

  // link side: frame toggle and response are quasi-static while selected
  assign new_frame = (frame_tgl_q != tgl_seen_q);
  always_ff @(posedge spi_sclk_i) begin
    if (!rst_n_i) begin
      tgl_seen_q <= 1'b1;
      bitcnt_q <= '0;
      shin_q <= '0;
      shout_q <= '0;
    end else if (!spi_select_n_i) begin
      if (new_frame) begin
        tgl_seen_q <= frame_tgl_q;
        bitcnt_q <= 5'h01;
        shin_q <= {15'h0000, spi_mosi_i};
        shout_q <= {resp_q[14:0], 1'b0};
      end else begin
        if (bitcnt_q != BITCNT_SAT) begin
          bitcnt_q <= bitcnt_q + 1'b1;
        end
        shin_q <= {shin_q[14:0], spi_mosi_i};
        shout_q <= {shout_q[14:0], 1'b0};
      end
    end
  end
  assign spi_miso_o = new_frame ? resp_q[15] : shout_q[15];
  assign spi_miso_oe_o = !spi_select_n_i;

  // checks on the system clock domain
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_hold_len;
    $rose(pwr_q == SRWD_PWR_RUN) |-> $past(por_cnt_q) == POR_LAST;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold time wrong"); // RULE1
  property p_dip_ignored;
    pwr_q != SRWD_PWR_DOWN && uv_cnt_q != UV_LAST |=> pwr_q != SRWD_PWR_DOWN;
  endproperty
  a_dip_ignored: assert property (p_dip_ignored) else $error("short dip reset"); // RULE2
  property p_dip_resets;
    pwr_q != SRWD_PWR_DOWN && uv_cnt_q == UV_LAST && !pin_q[PIN_FALL_OK]
      |=> ##1 reset_out_n_oe_o;
  endproperty
  a_dip_resets: assert property (p_dip_resets) else $error("long dip missed"); // RULE3
  property p_hyst;
    pwr_q == SRWD_PWR_DOWN && !pin_q[PIN_RISE_OK] |=> pwr_q == SRWD_PWR_DOWN;
  endproperty
  a_hyst: assert property (p_hyst) else $error("left down below rise level"); // RULE4
  property p_reset_off;
    reset_active |=> drive_en_o == 5'h00 && !kline_tx_en_o;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("stage on in reset"); // RULE5
  property p_inhibit;
    pin_q[PIN_INHIBIT] |=> wd_cnt_q == '0 && !wd_pulse_q;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("watchdog runs inhibited"); // RULE6
  property p_restart;
    restart && wd_en |=> wd_cnt_q == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart"); // RULE8
  property p_pulse_len;
    $fell(wd_pulse_q) |-> $past(pulse_cnt_q) == PULSE_LAST;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong"); // RULE9
  property p_ovf_off;
    wd_ovf |-> ##2 drive_en_o == 5'h00 && reset_out_n_oe_o;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("outputs on after overflow"); // RULE10
  property p_keep_regs;
    wd_ovf |=> cmd_q == $past(cmd_q);
  endproperty
  a_keep_regs: assert property (p_keep_regs) else $error("overflow changed regs"); // RULE11
  property p_flag_set;
    wd_ovf |=> wdto_q && after_ovf_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timeout flag not set"); // RULE12
  property p_first_status;
    after_ovf_q |=> resp_q == {8'h00, $past(status)};
  endproperty
  a_first_status: assert property (p_first_status) else $error("status not sent"); // RULE13
  property p_flag_clear;
    rd_status && !wd_ovf |=> !wdto_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // RULE16
endmodule : srwd_supervisor

`default_nettype wire

// File: tb/srwd_host_model.sv
// host-side spi master model for the supervisor's serial port
`default_nettype none

module srwd_host_model (
  input wire logic miso_i,
  output logic sclk_o,
  output logic sel_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 24;

  // idle levels of the pulled pins
  initial begin
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // clock pulses with select idle, only while reset is held
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
  endtask : pulses

  // one frame of n bits, msb first; valid frames keep the watchdog quiet
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    sel_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      mosi_o = tx[i % 16];
      #HALF rx = {rx[14:0], miso_i};
      sclk_o = 1'b1;
      #HALF sclk_o = 1'b0;
    end
    mosi_o = 1'b0; // pull-down level once released
    #HALF sel_n_o = 1'b1;
    #500;
  endtask : xfer
endmodule : srwd_host_model

`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the supply reset and watchdog supervisor
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int POR = 50;
  localparam int UV = 5;
  localparam int WDP = 400;
  localparam int WDR = 20;
  logic clk, rst_n, rise, fall, inh, ca, cc, sclk, sel_n, mosi, miso, miso_oe, ro_n, ro_oe, ktx;
  logic [4:0] drv;
  logic [15:0] rx;
  int errors, n_tests, cyc, n;

  srwd_supervisor #(.POR_HOLD_CYC_P(POR), .UV_FILTER_CYC_P(UV), .WD_PERIOD_CYC_P(WDP),
    .WD_PULSE_CYC_P(WDR)) dut (
    .clk_i(clk), .rst_n_i(rst_n), .rail_above_rise_thr_i(rise), .rail_above_fall_thr_i(fall),
    .watchdog_inhibit_i(inh), .direct_drive_ctrl_a_i(ca), .direct_drive_ctrl_c_i(cc),
    .spi_sclk_i(sclk), .spi_select_n_i(sel_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .spi_miso_oe_o(miso_oe), .reset_out_n_o(ro_n), .reset_out_n_oe_o(ro_oe),
    .drive_en_o(drv), .kline_tx_en_o(ktx));

  srwd_host_model host (.miso_i(miso), .sclk_o(sclk), .sel_n_o(sel_n), .mosi_o(mosi));

  // system clock
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      results();
    end
  end

  task automatic results();
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask : step

  task automatic rail(input logic r, input logic f);
    @(negedge clk);
    rise = r;
    fall = f;
  endtask : rail

  task automatic frame(input logic [15:0] tx, input int nb);
    host.xfer(tx, nb, rx);
  endtask : frame

  // bounded wait for the reset pin enable to reach a level
  task automatic wait_oe(input logic v, input int lim, output int k);
    k = 0;
    while (ro_oe !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_oe

  // outputs parked and a command write sent while supply is down
  task automatic t_down();
    step(6);
    check(16'(ro_oe), 16'h1);
    check({10'h0, drv, ktx}, 16'h0);
    check({14'h0, ro_n, miso_oe}, 16'h0);
    frame(16'h8107, 16);
  endtask : t_down

  // power-up hold, then the ignored write must not have landed
  task automatic t_power_up();
    rail(1'b1, 1'b1);
    step(POR);
    check(16'(ro_oe), 16'h1);
    wait_oe(1'b0, 20, n);
    check(16'(ro_oe), 16'h0);
    check(16'(ktx), 16'h1);
    frame(16'h0100, 16);
    frame(16'h0100, 16);
    check(rx, 16'h0000);
  endtask : t_power_up

  // short dip filtered, long dip resets, release needs the upper threshold
  task automatic t_glitch();
    rail(1'b0, 1'b0);
    step(UV - 2);
    rail(1'b1, 1'b1);
    step(12);
    check(16'(ro_oe), 16'h0);
    rail(1'b0, 1'b0);
    step(UV + 8);
    check(16'(ro_oe), 16'h1);
    rail(1'b0, 1'b1);
    step(POR + 20);
    check(16'(ro_oe), 16'h1);
    rail(1'b1, 1'b1);
    step(POR + 12);
    check(16'(ro_oe), 16'h0);
  endtask : t_glitch

  // restarts, bad frames, overflow pulse and recovery of each output
  task automatic t_watchdog();
    @(negedge clk);
    inh = 1'b0;
    ca = 1'b1;
    cc = 1'b1;
    frame(16'h8107, 16);
    step(8);
    check({11'h0, drv & 5'h1a}, 16'h1a);
    repeat (3) begin
      step(300);
      frame(16'h0000, 16);
    end
    check(16'(ro_oe), 16'h0);
    step(150);
    frame(16'h0000, 15);
    step(120);
    frame(16'h0000, 17);
    wait_oe(1'b1, 150, n);
    check(16'(n < 150), 16'h1);
    check({10'h0, drv, ktx}, 16'h0);
    wait_oe(1'b0, 40, n);
    check(16'(n), 16'(WDR));
    step(10);
    check({11'h0, drv}, 16'h0);
    frame(16'h0100, 16);
    check(rx, 16'h0001);
    frame(16'h0000, 16);
    check(rx, 16'h0007);
    frame(16'h0000, 16);
    check(rx, 16'h0001);
    frame(16'h0000, 16);
    check(rx, 16'h0000);
    @(negedge clk);
    ca = 1'b0;
    step(6);
    ca = 1'b1;
    step(8);
    check({11'h0, drv}, 16'h01);
    cc = 1'b0;
    step(6);
    cc = 1'b1;
    step(8);
    check({11'h0, drv}, 16'h05);
    frame(16'h8107, 16);
    step(8);
    check({11'h0, drv}, 16'h1f);
  endtask : t_watchdog

  // inhibited watchdog stays silent with no frames
  task automatic t_inhibit();
    @(negedge clk);
    inh = 1'b1;
    step(WDP * 3);
    check(16'(ro_oe), 16'h0);
    check({11'h0, drv}, 16'h1f);
  endtask : t_inhibit

  // main sequence
  initial begin
    rst_n = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    inh = 1'b1;
    ca = 1'b0;
    cc = 1'b0;
    errors = 0;
    n_tests = 0;
    cyc = 0;
    host.pulses(3);
    step(3);
    rst_n = 1'b1;
    t_down();
    t_power_up();
    t_glitch();
    t_watchdog();
    t_inhibit();
    results();
  end
endmodule : testbench

`default_nettype wire
